/* File: otp_pkg.sv */
// package: constants for the byte-wide otp rom access controller
// How it works
// - read: chip select and output gate low, normal supply; device drives
// - output gate may lag chip select by access minus gate delay
// - program: high supply, gate high, stable data, pulse chip select
// - program pulse lasts 95 to 105 us, nominal 100
// - up to ten 100 us pulses, verify after each, stop on pass
// - verify: high supply, chip select high, gate low; device drives
// - identity: high voltage on line, enables low; bit 0 picks byte
// - first pulse width within plus or minus 5 percent of nominal
package otp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ACCESS_NS = 90;
  localparam int GATE_NS = 40;
  localparam int FLOAT_NS = 30;
  localparam int PULSE_US = 100;
  localparam int SETUP_US = 2;
  localparam int MAX_PULSES = 10;
  localparam int IDENT_LINE_BIT = 9;
  // least times round up
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS + 1;
  localparam int FLOAT_CYC = (FLOAT_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS + 1;
  localparam int PULSE_CYC = (PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_IDENT = 2'h2;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SETUP = 8'h02,
    ST_ACCESS = 8'h04,
    ST_PULSE = 8'h08,
    ST_VSETUP = 8'h10,
    ST_VERIFY = 8'h20,
    ST_FLOAT = 8'h40,
    ST_DONE = 8'h80
  } otp_state_t;
endpackage

/* File: otp_sync.sv */
// three-stage input synchroniser, accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module otp_sync #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire logic [W-1:0] agree = ~(s2_q ^ s3_q);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end
  assign sync_out = out_q;
endmodule
`default_nettype wire

/* File: otp_host.sv */
// host controller driving the otp rom pins for read, identity and program
`timescale 1ns/1ps
`default_nettype none
module otp_host #(
  parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC,
  parameter int SETUP_CYCLES = otp_pkg::SETUP_CYC,
  parameter int MAX_TRIES = otp_pkg::MAX_PULSES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [otp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [otp_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [otp_pkg::DATA_W-1:0] rsp_rdata,
  output logic rsp_fail,
  output logic [3:0] rsp_pulses,
  output logic [otp_pkg::ADDR_W-1:0] byte_address,
  output logic identity_select_line,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic prog_supply_high,
  output logic [otp_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [otp_pkg::DATA_W-1:0] data_pins_i
);
  // ==========================================================
  // parameter checks
  // ==========================================================
  if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << otp_pkg::CNT_W))
  begin : g_bad_pulse
    $error("pulse cycles out of range");
  end
  if (SETUP_CYCLES < 1 || SETUP_CYCLES >= (1 << otp_pkg::CNT_W))
  begin : g_bad_setup
    $error("setup cycles out of range");
  end
  if (MAX_TRIES < 1 || MAX_TRIES > 15)
  begin : g_bad_tries
    $error("try count out of range");
  end

  // ==========================================================
  // input sampling
  // ==========================================================
  logic [otp_pkg::DATA_W-1:0] rd_sync;
  otp_sync #(.W(otp_pkg::DATA_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(data_pins_i),
    .sync_out(rd_sync)
  );
  // sampling adds sync latency on top of access time
  localparam int SYNC_LAT = 4;

  // ==========================================================
  // state and datapath
  // ==========================================================
  otp_pkg::otp_state_t st_q, st_d;
  logic [otp_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] tries_q, tries_d;
  logic [1:0] op_q;
  logic [otp_pkg::DATA_W-1:0] wdata_q;

  function automatic logic [otp_pkg::CNT_W-1:0] cyc(input int n);
    cyc = otp_pkg::CNT_W'(n - 1);
  endfunction

  wire logic cnt_zero = (cnt_q == '0);
  // every bit matters: stored byte must equal wanted byte
  wire logic verify_ok = (rd_sync == wdata_q);
  wire logic tries_left = (tries_q < 4'(MAX_TRIES));
  wire logic take = req_valid && (st_q == otp_pkg::ST_IDLE);

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    tries_d = tries_q;
    case (st_q)
      otp_pkg::ST_IDLE:
        if (take)
        begin
          tries_d = '0;
          if (req_op == otp_pkg::OP_PROG)
          begin
            st_d = otp_pkg::ST_SETUP;
            cnt_d = cyc(SETUP_CYCLES);
          end
          else
          begin
            st_d = otp_pkg::ST_ACCESS;
            cnt_d = cyc(otp_pkg::ACCESS_CYC + SYNC_LAT);
          end
        end
      otp_pkg::ST_ACCESS:
        if (cnt_zero)
        begin
          st_d = otp_pkg::ST_FLOAT;
          cnt_d = cyc(otp_pkg::FLOAT_CYC);
        end
      otp_pkg::ST_SETUP:
        if (cnt_zero)
        begin
          st_d = otp_pkg::ST_PULSE;
          cnt_d = cyc(PULSE_CYCLES);
          tries_d = tries_q + 4'h1;
        end
      otp_pkg::ST_PULSE:
        if (cnt_zero)
        begin
          st_d = otp_pkg::ST_VSETUP;
          cnt_d = cyc(SETUP_CYCLES);
        end
      otp_pkg::ST_VSETUP:
        if (cnt_zero)
        begin
          st_d = otp_pkg::ST_VERIFY;
          cnt_d = cyc(otp_pkg::ACCESS_CYC + SYNC_LAT);
        end
      otp_pkg::ST_VERIFY:
        if (cnt_zero)
        begin
          if (verify_ok || !tries_left)
          begin
            st_d = otp_pkg::ST_FLOAT;
            cnt_d = cyc(otp_pkg::FLOAT_CYC);
          end
          else
          begin
            st_d = otp_pkg::ST_SETUP;
            cnt_d = cyc(SETUP_CYCLES);
          end
        end
      otp_pkg::ST_FLOAT:
        if (cnt_zero)
          st_d = otp_pkg::ST_DONE;
      otp_pkg::ST_DONE:
        st_d = otp_pkg::ST_IDLE;
      default:
        st_d = otp_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // pin decode
  // ==========================================================
  wire logic is_prog = (op_q == otp_pkg::OP_PROG);
  wire logic in_prog_seq = (st_q == otp_pkg::ST_SETUP) ||
    (st_q == otp_pkg::ST_PULSE) || (st_q == otp_pkg::ST_VSETUP) ||
    (st_q == otp_pkg::ST_VERIFY);
  // chip select low for read/identity access, or during a program pulse
  wire logic cs_n_d = !((st_q == otp_pkg::ST_ACCESS) ||
    (st_d == otp_pkg::ST_ACCESS) || (st_d == otp_pkg::ST_PULSE));
  // gate low for read access and verify; high while programming
  wire logic og_n_d = !((st_d == otp_pkg::ST_ACCESS) ||
    (st_d == otp_pkg::ST_VERIFY));
  // high supply only from a program take to its done, never on a read take
  wire logic vpp_d = (is_prog && (in_prog_seq ||
    (st_q == otp_pkg::ST_FLOAT))) ||
    (take && req_op == otp_pkg::OP_PROG);
  // drive data only while gate is high and programming
  wire logic drv_d = (st_d == otp_pkg::ST_SETUP) ||
    (st_d == otp_pkg::ST_PULSE);
  wire logic done_d = (st_q == otp_pkg::ST_FLOAT) && cnt_zero;
  wire logic capture = (st_q == otp_pkg::ST_ACCESS ||
    st_q == otp_pkg::ST_VERIFY) && cnt_zero;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= otp_pkg::ST_IDLE;
      cnt_q <= '0;
      tries_q <= '0;
      op_q <= otp_pkg::OP_READ;
      wdata_q <= '1;
      byte_address <= '0;
      identity_select_line <= 1'b0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      prog_supply_high <= 1'b0;
      data_pins_o <= '1;
      data_pins_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_fail <= 1'b0;
      rsp_pulses <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tries_q <= tries_d;
      if (take)
      begin
        op_q <= req_op;
        wdata_q <= req_wdata;
        byte_address <= req_addr;
        // identity: high voltage on the line, bit 0 picks code byte
        identity_select_line <= (req_op == otp_pkg::OP_IDENT);
      end
      chip_select_n <= cs_n_d;
      output_gate_n <= og_n_d;
      prog_supply_high <= vpp_d;
      data_pins_o <= wdata_q;
      data_pins_oe <= drv_d;
      req_ready <= (st_d == otp_pkg::ST_IDLE);
      rsp_valid <= done_d;
      if (capture)
        rsp_rdata <= rd_sync;
      if (done_d)
      begin
        rsp_fail <= is_prog && (rsp_rdata != wdata_q);
        rsp_pulses <= tries_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: otp_host_checker.sv */
// checker: pin protocol of the otp host controller
`timescale 1ns/1ps
`default_nettype none
module otp_host_checker #(
  parameter int PULSE_CYCLES = 20,
  parameter int MAX_TRIES = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rsp_valid,
  input wire logic rsp_fail,
  input wire logic [3:0] rsp_pulses,
  input wire logic [14:0] byte_address,
  input wire logic identity_select_line,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic prog_supply_high,
  input wire logic [7:0] data_pins_o,
  input wire logic data_pins_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // =====
  // cycles of the current program pulse
  logic [15:0] pw_q;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) pw_q <= 16'h0;
    else pw_q <= (!chip_select_n && prog_supply_high) ? pw_q + 16'h1 : 16'h0;
  sequence s_read_go;
    $fell(output_gate_n) && !chip_select_n && !prog_supply_high;
  endsequence
  sequence s_pulse_end;
    $rose(chip_select_n) && prog_supply_high;
  endsequence
  sequence s_read_end;
    $rose(output_gate_n) && !prog_supply_high;
  endsequence
  a_gate_read_hold: assert property (s_read_go
    |-> (!output_gate_n)[*8])
    else $error("read gate dropped before access time");
  a_float_wait: assert property (s_read_end |-> (!data_pins_oe)[*3])
    else $error("host drove before outputs float");
  a_pulse_width: assert property (s_pulse_end |-> pw_q == PULSE_CYCLES)
    else $error("program pulse width wrong");
  a_prog_gate_high: assert property (!chip_select_n && prog_supply_high
    |-> output_gate_n && data_pins_oe) else $error("program pins wrong");
  a_pulse_stable: assert property (!chip_select_n && prog_supply_high &&
    $past(chip_select_n) == 1'h0 |-> $stable(data_pins_o) &&
    $stable(byte_address)) else $error("data moved during pulse");
  a_no_contention: assert property (!output_gate_n |-> !data_pins_oe)
    else $error("host drives while device gated on");
  a_verify_cs_high: assert property (prog_supply_high && !output_gate_n
    |-> chip_select_n) else $error("verify with chip select low");
  a_ident_normal: assert property (identity_select_line
    |-> !prog_supply_high) else $error("identity with high supply");
  a_fail_tries: assert property (rsp_valid && rsp_fail
    |-> rsp_pulses == MAX_TRIES) else $error("failed before last try");
  a_tries_bound: assert property (rsp_valid |-> rsp_pulses <= MAX_TRIES)
    else $error("too many pulses");
endmodule
`default_nettype wire

/* File: otp_rom_model.sv */
// behavioural model of the byte-wide otp rom
`timescale 1ns/1ps
`default_nettype none
module otp_rom_model #(
  parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] PART = 8'h3c // arbitrary value
) (
  input wire logic [14:0] byte_address,
  input wire logic identity_select_line,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic prog_supply_high,
  input wire logic host_oe,
  input wire logic [7:0] host_d,
  output var logic [7:0] dq
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  wire read_m = !chip_select_n && !output_gate_n && !prog_supply_high;
  wire ver_m = prog_supply_high && chip_select_n && !output_gate_n;
  wire dev_oe = read_m || ver_m;
  wire [7:0] id = byte_address[0] ? PART : MAKER;
  wire [7:0] dev_d = (identity_select_line && read_m) ? id : mem[byte_address];
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(negedge chip_select_n)
    if (prog_supply_high && output_gate_n)
      mem[byte_address] = mem[byte_address] & host_d;
  always @*
    if (host_oe) last = host_d;
    else if (dev_oe) last = dev_d;
  // released lines show the inverse of the last value
  assign #40 dq = host_oe ? host_d : (dev_oe ? dev_d : ~last);
endmodule
`default_nettype wire

/* File: tb_byte_wide_otp_rom_access.sv */
// testbench for the otp host controller
`timescale 1ns/1ps
`default_nettype none
module tb_byte_wide_otp_rom_access;
  typedef struct {logic [1:0] op; logic [14:0] a; logic [7:0] w;
    logic [7:0] r; logic f; logic [3:0] p;} otp_row_t;
  logic core_clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0;
  logic [1:0] req_op = 2'h0;
  logic [14:0] req_addr = 15'h0;
  logic [7:0] req_wdata = 8'h0;
  logic req_ready, rsp_valid, rsp_fail, identity_select_line;
  logic chip_select_n, output_gate_n, prog_supply_high, data_pins_oe;
  logic [3:0] rsp_pulses;
  logic [7:0] rsp_rdata, data_pins_o;
  logic [14:0] byte_address;
  wire logic [7:0] data_pins_i;
  int fails = 0, checks_done = 0, cyc = 0;
  // =====
  // rows: op, address, write byte, result byte, fail, pulses
  otp_row_t rows [8] = '{'{2'h0, 15'h0005, 8'h00, 8'hff, 1'h0, 4'h0},
    '{2'h1, 15'h0005, 8'ha5, 8'ha5, 1'h0, 4'h1},
    '{2'h0, 15'h0005, 8'h00, 8'ha5, 1'h0, 4'h1},
    '{2'h1, 15'h7fff, 8'h00, 8'h00, 1'h0, 4'h1},
    '{2'h0, 15'h7fff, 8'h00, 8'h00, 1'h0, 4'h1},
    '{2'h1, 15'h0005, 8'h0f, 8'h05, 1'h1, 4'ha},
    '{2'h2, 15'h0000, 8'h00, 8'h5a, 1'h0, 4'ha},
    '{2'h2, 15'h0001, 8'h00, 8'h3c, 1'h0, 4'ha}};
  otp_host #(.PULSE_CYCLES(20), .SETUP_CYCLES(3)) DUT (.*);
  otp_rom_model #(.MAKER(8'h5a), .PART(8'h3c)) MDL (.byte_address,
    .identity_select_line, .chip_select_n, .output_gate_n, .prog_supply_high,
    .host_oe(data_pins_oe), .host_d(data_pins_o), .dq(data_pins_i));
  initial forever #5 core_clk = ~core_clk;
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      final_report;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_op(input otp_row_t x);
    @(posedge core_clk);
    req_valid <= 1'h1;
    req_op <= x.op;
    req_addr <= x.a;
    req_wdata <= x.w;
    do @(negedge core_clk); while (req_ready !== 1'h1);
    @(posedge core_clk);
    req_valid <= 1'h0;
    do @(negedge core_clk); while (rsp_valid !== 1'h1);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (rows[i])
    begin
      do_op(rows[i]);
      chk(rsp_rdata, rows[i].r);
      if (rows[i].op == 2'h1)
        chk({3'h0, rsp_fail, rsp_pulses}, {3'h0, rows[i].f, rows[i].p});
      $display("test %0d done", i);
    end
    @(posedge core_clk);
    req_valid <= 1'h1;
    req_op <= 2'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h0;
    req_valid <= 1'h0;
    @(negedge core_clk);
    chk({3'h0, chip_select_n, output_gate_n, data_pins_oe, prog_supply_high,
      req_ready}, 8'h18);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    do_op('{2'h0, 15'h0005, 8'h00, 8'h05, 1'h0, 4'h0});
    chk(rsp_rdata, 8'h05);
    $display("test reset done");
    final_report;
  end
endmodule
bind otp_host otp_host_checker #(.PULSE_CYCLES(PULSE_CYCLES),
  .MAX_TRIES(MAX_TRIES)) u_chk (.*);
`default_nettype wire
